// ===== verilog/rco_consts.vh
/*
 * constants of the reference clock and clock output configuration block:
 * serial-bus address, register offsets, bit positions, reset values,
 * select-pin level codes and detector current codes.
 * assumes it is included by bare name by every design file that needs it.
 */
`ifndef RCO_CONSTS_VH
`define RCO_CONSTS_VH

// serial-bus device address, arbitrary value
`define RCO_DEV_ADDR          7'h60

// register offsets
`define RCO_OFS_REF_FREQ      8'h01
`define RCO_OFS_CLK_BUF       8'h05
`define RCO_OFS_EXT_AMP       8'h06
`define RCO_OFS_DETECTOR      8'h07
`define RCO_OFS_STATUS        8'h08

// reference_frequency_control fields
`define RCO_BIT_REF_FREQ      0

// clock_buffer_control fields
`define RCO_BIT_DRIVE_SHAPE   0
`define RCO_BIT_BUF_DISABLE   1
`define RCO_BIT_OVERRIDE      2
`define RCO_BIT_BUF_MODE      3

// external_amplifier_control fields
`define RCO_BIT_AMP_GAIN      0
`define RCO_BIT_AMP_MODE      1

// detector current fields: charge 680 + 20*code uA, discharge 10 + 5*code uA
`define RCO_DET_CHG_LSB       0
`define RCO_DET_CHG_MSB       3
`define RCO_DET_DIS_LSB       4
`define RCO_DET_DIS_MSB       6
`define RCO_DET_CHG_MAX       4'hE
`define RCO_DET_DIS_MAX       3'h6

// reset values
`define RCO_RST_REF_FREQ      8'h00
`define RCO_RST_CLK_BUF       8'h00
`define RCO_RST_EXT_AMP       8'h00
`define RCO_RST_DETECTOR      8'h36

// select-pin level codes from the four-level comparator
`define RCO_SEL_VCC           2'h3
`define RCO_SEL_TWO_THIRDS    2'h2
`define RCO_SEL_ONE_THIRD     2'h1
`define RCO_SEL_GND           2'h0

// cycles after reset release before the strap level is trusted
`define RCO_STRAP_WAIT        2'h3

`endif

// ===== verilog/rco_sync.v
/*
 * two flip-flop synchroniser for a bundle of independent levels.
 * assumes each bit changes slowly compared with the clock, and that
 * only the second stage is read by other logic.
 */
`timescale 1ns/1ps
`default_nettype none

module rco_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input  wire             clock,  // block clock
    input  wire             rst_n,  // async reset, active low
    input  wire             ce,     // clock enable
    input  wire [WIDTH-1:0] d,      // asynchronous input
    output reg  [WIDTH-1:0] q       // synchronised output
);

    reg [WIDTH-1:0] meta_reg;

    // two stages, the first read only by the second
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_VAL;
            q        <= RESET_VAL;
        end else if (ce) begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ===== verilog/rco_ref_clock_config.v
/*
 * reference clock and clock output configuration with its serial-bus
 * register slave, select-pin strap decode and external amplifier pin.
 * assumes an open-drain two-wire bus with external pull-ups, a select
 * pin already turned into a two-bit level code by comparators, and a
 * reference clock input slower than half the block clock.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rco_consts.vh"

// How it works
// - select pin at supply or open: 26 MHz, single-ended buffer.
// - select pin at two thirds supply: 26 MHz, differential buffer.
// - select pin at one third supply: 36 MHz, single-ended buffer.
// - select pin grounded: 36 MHz, differential buffer.
// - single-ended output starts square, shape bit cleared at reset.
// - differential drive 500 uA with shape bit zero, 1 mA when one.
// - single-ended with shape bit one gives sine-like output.
// - buffer-disable bit high switches off the active output buffer.
// - exactly one buffer mode is in effect, never both.
// - differential mode drives clock on true and complement pins.
// - single-ended mode drives clock on the true pin only.
// - override bit set: frequency and mode come from register bits.
// - override bit resets to zero, so the pin decode rules.
// - amplifier mode bit zero: amplifier pin is push-pull.
// - amplifier pin follows the gain-select bit.
// - open-drain amplifier pin option; software minds polarity and timing.
// - charge current settable 680 to 960 uA, nominal 800 uA.
// - discharge current settable 10 to 40 uA, nominal 25 uA.
// - bus pull-ups are external; pins are plain open-drain.
module rco_ref_clock_config #(
    parameter [6:0] DEV_ADDR = `RCO_DEV_ADDR
) (
    input  wire       clock,                               // 100 MHz block clock
    input  wire       rst_n,                               // async reset, active low
    input  wire       ce,                                  // clock enable
    input  wire       scl_in,                              // bus clock level
    input  wire       sda_in,                              // bus data level
    output wire       sda_out,                             // bus data drive value
    output wire       sda_oe_n,                            // low while pulling data low
    input  wire [1:0] clock_select_level,                  // four-level pin code
    input  wire       reference_input_pin,                 // reference clock in
    output reg        clock_output_true,                   // clock output, true pin
    output reg        clock_output_complement,             // clock output, complement
    output reg        reference_select_36,                 // 1 = 36 MHz, 0 = 26 MHz
    output reg        differential_mode,                   // 1 = differential buffer
    output reg        drive_current_high,                  // differential 1 mA drive
    output reg        single_ended_sine,                   // single-ended sine shape
    output reg        buffer_enabled,                      // active buffer running
    output reg        external_amplifier_control_pin_out,  // amplifier pin value
    output reg        external_amplifier_control_pin_oe_n, // low while driving
    output reg  [3:0] detector_charge_code,                // charge current code
    output reg  [2:0] detector_discharge_code              // discharge current code
);

    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_PTR   = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_RDATA = 3'h4;
    localparam [2:0] ST_ACK   = 3'h5;
    localparam [2:0] ST_RACK  = 3'h6;

    wire       rst_sync_n;
    wire       scl_s;
    wire       sda_s;
    wire [1:0] sel_s;
    wire       ref_s;

    reg        scl_d_reg;
    reg        sda_d_reg;
    reg  [2:0] state_reg;
    reg  [2:0] after_ack_reg;
    reg  [3:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg  [7:0] rd_shift_reg;
    reg  [7:0] pointer_reg;
    reg        sda_low_reg;
    reg        master_nack_reg;

    reg  [7:0] ref_freq_ctl_reg;
    reg  [7:0] clk_buf_ctl_reg;
    reg  [7:0] ext_amp_ctl_reg;
    reg  [7:0] detector_ctl_reg;

    reg  [1:0] strap_wait_reg;
    reg        strap_done_reg;
    reg        strap_freq36_reg;
    reg        strap_diff_reg;
    reg  [1:0] strap_code_reg;

    reg  [7:0] rd_data;
    reg        eff_freq36;
    reg        eff_diff;

    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    wire byte_done  = (bit_cnt_reg == 4'h8);

    // reset release through two flip-flops
    rco_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (1'b1),
        .d     (1'b1),
        .q     (rst_sync_n)
    );

    // bus pins, select pin and reference clock into the block domain
    rco_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
        .clock (clock),
        .rst_n (rst_sync_n),
        .ce    (ce),
        .d     ({scl_in, sda_in}),
        .q     ({scl_s, sda_s})
    );

    rco_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_pin_sync (
        .clock (clock),
        .rst_n (rst_sync_n),
        .ce    (ce),
        .d     ({clock_select_level, reference_input_pin}),
        .q     ({sel_s, ref_s})
    );

    // open-drain data pin: only ever pulled low, pull-up is external
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~sda_low_reg;

    // register read mux, unmapped offsets read zero
    always @* begin
        case (pointer_reg)
            `RCO_OFS_REF_FREQ: rd_data = ref_freq_ctl_reg;
            `RCO_OFS_CLK_BUF:  rd_data = clk_buf_ctl_reg;
            `RCO_OFS_EXT_AMP:  rd_data = ext_amp_ctl_reg;
            `RCO_OFS_DETECTOR: rd_data = detector_ctl_reg;
            `RCO_OFS_STATUS:   rd_data = {3'h0, buffer_enabled, strap_code_reg,
                                          differential_mode, reference_select_36};
            default:           rd_data = 8'h00;
        endcase
    end

    // bus slave: byte shifting, acknowledge and register pointer
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scl_d_reg        <= 1'b1;
            sda_d_reg        <= 1'b1;
            state_reg        <= ST_IDLE;
            after_ack_reg    <= ST_IDLE;
            bit_cnt_reg      <= 4'h0;
            shift_reg        <= 8'h00;
            rd_shift_reg     <= 8'h00;
            pointer_reg      <= 8'h00;
            sda_low_reg      <= 1'b0;
            master_nack_reg  <= 1'b0;
            ref_freq_ctl_reg <= `RCO_RST_REF_FREQ;
            clk_buf_ctl_reg  <= `RCO_RST_CLK_BUF;
            ext_amp_ctl_reg  <= `RCO_RST_EXT_AMP;
            detector_ctl_reg <= `RCO_RST_DETECTOR;
        end else if (ce) begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            if (start_cond) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                sda_low_reg <= 1'b0;
            end else if (stop_cond) begin
                state_reg   <= ST_IDLE;
                sda_low_reg <= 1'b0;
            end else if (scl_rise) begin
                if (state_reg == ST_ADDR || state_reg == ST_PTR ||
                    state_reg == ST_WDATA) begin
                    shift_reg   <= {shift_reg[6:0], sda_s};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end else if (state_reg == ST_RACK) begin
                    master_nack_reg <= sda_s;
                end
            end else if (scl_fall) begin
                case (state_reg)
                    ST_ADDR: begin
                        if (byte_done) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                state_reg     <= ST_ACK;
                                sda_low_reg   <= 1'b1;
                                after_ack_reg <= shift_reg[0] ? ST_RDATA : ST_PTR;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_PTR: begin
                        if (byte_done) begin
                            pointer_reg   <= shift_reg;
                            state_reg     <= ST_ACK;
                            sda_low_reg   <= 1'b1;
                            after_ack_reg <= ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (byte_done) begin
                            case (pointer_reg)
                                `RCO_OFS_REF_FREQ: ref_freq_ctl_reg <= shift_reg;
                                `RCO_OFS_CLK_BUF:  clk_buf_ctl_reg  <= shift_reg;
                                `RCO_OFS_EXT_AMP:  ext_amp_ctl_reg  <= shift_reg;
                                `RCO_OFS_DETECTOR: detector_ctl_reg <= shift_reg;
                                default:           ;
                            endcase
                            pointer_reg   <= pointer_reg + 8'h01;
                            state_reg     <= ST_ACK;
                            sda_low_reg   <= 1'b1;
                            after_ack_reg <= ST_WDATA;
                        end
                    end
                    ST_ACK: begin
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= after_ack_reg;
                        if (after_ack_reg == ST_RDATA) begin
                            rd_shift_reg <= rd_data;
                            sda_low_reg  <= ~rd_data[7];
                            pointer_reg  <= pointer_reg + 8'h01;
                        end else begin
                            sda_low_reg <= 1'b0;
                        end
                    end
                    ST_RDATA: begin
                        if (bit_cnt_reg == 4'h7) begin
                            sda_low_reg <= 1'b0;
                            state_reg   <= ST_RACK;
                        end else begin
                            bit_cnt_reg  <= bit_cnt_reg + 4'h1;
                            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
                            sda_low_reg  <= ~rd_shift_reg[6];
                        end
                    end
                    ST_RACK: begin
                        bit_cnt_reg <= 4'h0;
                        if (master_nack_reg) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            state_reg    <= ST_RDATA;
                            rd_shift_reg <= rd_data;
                            sda_low_reg  <= ~rd_data[7];
                            pointer_reg  <= pointer_reg + 8'h01;
                        end
                    end
                    default: begin
                        sda_low_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // catch the select pin code once, shortly after reset release
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            strap_wait_reg   <= 2'h0;
            strap_done_reg   <= 1'b0;
            strap_code_reg   <= `RCO_SEL_VCC;
            strap_freq36_reg <= 1'b0;
            strap_diff_reg   <= 1'b0;
        end else if (ce && !strap_done_reg) begin
            if (strap_wait_reg == `RCO_STRAP_WAIT) begin
                strap_done_reg <= 1'b1;
                strap_code_reg <= sel_s;
                case (sel_s)
                    `RCO_SEL_VCC: begin
                        strap_freq36_reg <= 1'b0;
                        strap_diff_reg   <= 1'b0;
                    end
                    `RCO_SEL_TWO_THIRDS: begin
                        strap_freq36_reg <= 1'b0;
                        strap_diff_reg   <= 1'b1;
                    end
                    `RCO_SEL_ONE_THIRD: begin
                        strap_freq36_reg <= 1'b1;
                        strap_diff_reg   <= 1'b0;
                    end
                    default: begin
                        strap_freq36_reg <= 1'b1;
                        strap_diff_reg   <= 1'b1;
                    end
                endcase
            end else begin
                strap_wait_reg <= strap_wait_reg + 2'h1;
            end
        end
    end

    // override picks register bits over the pin decode
    always @* begin
        if (clk_buf_ctl_reg[`RCO_BIT_OVERRIDE]) begin
            eff_freq36 = ref_freq_ctl_reg[`RCO_BIT_REF_FREQ];
            eff_diff   = clk_buf_ctl_reg[`RCO_BIT_BUF_MODE];
        end else begin
            eff_freq36 = strap_freq36_reg;
            eff_diff   = strap_diff_reg;
        end
    end

    // clock output buffer: one mode only, gated by the disable bit
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reference_select_36     <= 1'b0;
            differential_mode       <= 1'b0;
            drive_current_high      <= 1'b0;
            single_ended_sine       <= 1'b0;
            buffer_enabled          <= 1'b0;
            clock_output_true       <= 1'b0;
            clock_output_complement <= 1'b0;
            detector_charge_code    <= 4'h0;
            detector_discharge_code <= 3'h0;
        end else if (ce) begin
            reference_select_36 <= eff_freq36;
            differential_mode   <= eff_diff;
            drive_current_high  <= eff_diff &
                                   clk_buf_ctl_reg[`RCO_BIT_DRIVE_SHAPE];
            single_ended_sine   <= ~eff_diff &
                                   clk_buf_ctl_reg[`RCO_BIT_DRIVE_SHAPE];
            buffer_enabled      <= strap_done_reg &
                                   ~clk_buf_ctl_reg[`RCO_BIT_BUF_DISABLE];
            clock_output_true   <= buffer_enabled & ref_s;
            clock_output_complement <= buffer_enabled & differential_mode & ~ref_s;
            // clamp out-of-range current codes to the top setting
            detector_charge_code <=
                (detector_ctl_reg[`RCO_DET_CHG_MSB:`RCO_DET_CHG_LSB] > `RCO_DET_CHG_MAX) ?
                `RCO_DET_CHG_MAX : detector_ctl_reg[`RCO_DET_CHG_MSB:`RCO_DET_CHG_LSB];
            detector_discharge_code <=
                (detector_ctl_reg[`RCO_DET_DIS_MSB:`RCO_DET_DIS_LSB] > `RCO_DET_DIS_MAX) ?
                `RCO_DET_DIS_MAX : detector_ctl_reg[`RCO_DET_DIS_MSB:`RCO_DET_DIS_LSB];
        end
    end

    // amplifier pin: push-pull, or open-drain pulling low for gain bit zero
    always @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            external_amplifier_control_pin_out  <= 1'b0;
            external_amplifier_control_pin_oe_n <= 1'b0;
        end else if (ce) begin
            if (!ext_amp_ctl_reg[`RCO_BIT_AMP_MODE]) begin
                external_amplifier_control_pin_out  <= ext_amp_ctl_reg[`RCO_BIT_AMP_GAIN];
                external_amplifier_control_pin_oe_n <= 1'b0;
            end else begin
                external_amplifier_control_pin_out  <= 1'b0;
                external_amplifier_control_pin_oe_n <= ext_amp_ctl_reg[`RCO_BIT_AMP_GAIN];
            end
        end
    end

endmodule

`default_nettype wire

// ===== test/rco_checker.sv
/* checker for the reference clock configuration block.
   assumes ce is held high and the bind below attaches it. */
`timescale 1ns/1ps
`default_nettype none
module rco_checker (
    input wire logic       clock,                               // block clock
    input wire logic       rst_n,                               // async reset
    input wire logic       sda_out,                             // bus data value
    input wire logic       clock_output_true,                   // true pin
    input wire logic       clock_output_complement,             // complement pin
    input wire logic       differential_mode,                   // diff buffer
    input wire logic       drive_current_high,                  // 1 mA drive
    input wire logic       single_ended_sine,                   // sine shape
    input wire logic       buffer_enabled,                      // buffer on
    input wire logic       external_amplifier_control_pin_out,  // amp value
    input wire logic       external_amplifier_control_pin_oe_n, // amp enable
    input wire logic [3:0] detector_charge_code,                // charge code
    input wire logic [2:0] detector_discharge_code              // discharge code
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // output relations
    one_mode_a: assert property (!(drive_current_high && single_ended_sine))
        else $error("drive and shape flags both set");
    comp_idle_a: assert property (
        !differential_mode ##1 !differential_mode |-> !clock_output_complement)
        else $error("complement active in single-ended mode");
    comp_inverse_a: assert property (
        (differential_mode && buffer_enabled)[*3] |->
        clock_output_complement != clock_output_true)
        else $error("complement not inverse of true pin");
    gate_off_a: assert property (
        !buffer_enabled[*3] |-> !clock_output_true && !clock_output_complement)
        else $error("clock output while buffer off");
    amp_drive_a: assert property (
        external_amplifier_control_pin_out |-> !external_amplifier_control_pin_oe_n)
        else $error("amplifier high value without drive");
    sda_value_a: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    charge_max_a: assert property (detector_charge_code <= 4'hE)
        else $error("charge code above range");
    dis_max_a: assert property (detector_discharge_code <= 3'h6)
        else $error("discharge code above range");
    start_quiet_a: assert property ($rose(rst_n) |-> !buffer_enabled[*4])
        else $error("buffer on before strap capture");
    start_up_a: assert property ($rose(rst_n) |-> ##[4:20] buffer_enabled)
        else $error("buffer not on after start-up");
endmodule
bind rco_ref_clock_config rco_checker i_rco_checker (
    .clock(clock), .rst_n(rst_n), .sda_out(sda_out),
    .clock_output_true(clock_output_true),
    .clock_output_complement(clock_output_complement),
    .differential_mode(differential_mode),
    .drive_current_high(drive_current_high),
    .single_ended_sine(single_ended_sine), .buffer_enabled(buffer_enabled),
    .external_amplifier_control_pin_out(external_amplifier_control_pin_out),
    .external_amplifier_control_pin_oe_n(external_amplifier_control_pin_oe_n),
    .detector_charge_code(detector_charge_code),
    .detector_discharge_code(detector_discharge_code));
`default_nettype wire

// ===== test/rco_host_model.sv
/* two-wire bus host model with the external pull-up on the data line.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
`default_nettype none
module rco_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h60  // arbitrary address
) (
    input  wire logic clock,    // paces bus phases
    input  wire logic sda_out,  // device data value
    input  wire logic sda_oe_n, // device data enable
    output var  logic scl,      // bus clock
    output var  logic sda       // resolved data line
);
    logic sda_low = 1'b0;
    initial scl = 1'b1;
    // pull-up wins unless someone pulls low
    assign sda = sda_low ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);
    task automatic q(input int n);
        repeat (n) @(negedge clock);
    endtask
    // start or repeated start
    task automatic start();
        sda_low = 1'b0;
        q(2);
        scl = 1'b1;
        q(2);
        sda_low = 1'b1;
        q(2);
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        q(2);
        scl = 1'b1;
        q(2);
        sda_low = 1'b0;
        q(2);
    endtask
    // nine bits: byte then acknowledge, 80 ns per bit
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low = !tx[i];
            q(2);
            scl = 1'b1;
            q(3);
            rx[i] = sda;
            q(1);
            scl = 1'b0;
            q(2);
        end
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
        logic [8:0] r;
        start();
        xfer({DEV_ADDR, 2'b01}, r);
        xfer({ofs, 1'b1}, r);
        xfer({d, 1'b1}, r);
        stop();
    endtask
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic [8:0] r;
        start();
        xfer({DEV_ADDR, 2'b01}, r);
        xfer({ofs, 1'b1}, r);
        start();
        xfer({DEV_ADDR, 2'b11}, r);
        xfer(9'h1FF, r);
        d = r[8:1];
        stop();
    endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
/* self-checking bench for the reference clock configuration block.
   assumes the checker is bound and the host model drives the bus. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       ref_in = 1'b0;
    logic [1:0] sel = 2'h3;
    logic       scl, sda, sda_out, sda_oe_n, clk_t, clk_c, ref36, diff;
    logic       drv_hi, sine, buf_en, amp_out, amp_oe_n;
    logic [3:0] chg;
    logic [2:0] dis;
    logic [7:0] rd;
    int         failures = 0;
    int         checks = 0;
    // 100 MHz block clock and a free reference near 26 MHz
    always #5 clock = ~clock;
    always #19 ref_in = ~ref_in;
    rco_ref_clock_config i_rco_ref_clock_config (.clock(clock), .rst_n(rst_n),
        .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .clock_select_level(sel), .reference_input_pin(ref_in),
        .clock_output_true(clk_t), .clock_output_complement(clk_c),
        .reference_select_36(ref36), .differential_mode(diff),
        .drive_current_high(drv_hi), .single_ended_sine(sine), .buffer_enabled(buf_en),
        .external_amplifier_control_pin_out(amp_out),
        .external_amplifier_control_pin_oe_n(amp_oe_n),
        .detector_charge_code(chg), .detector_discharge_code(dis));
    rco_host_model i_rco_host_model (.clock(clock), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
    task automatic stop_test();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // reset with a strap level, then wait for the buffer to start
    task automatic do_reset(input logic [1:0] lvl);
        int n;
        @(negedge clock);
        sel = lvl;
        rst_n = 1'b0;
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        for (n = 0; n < 30 && buf_en !== 1'b1; n++)
            @(negedge clock);
        if (n == 30) begin
            failures++;
            stop_test();
        end
    endtask
    // watch both clock pins for 40 cycles
    task automatic toggles(input logic exp_t, input logic exp_c);
        int nt = 0;
        int nc = 0;
        logic pt = clk_t;
        logic pc = clk_c;
        repeat (40) begin
            @(negedge clock);
            nt += (clk_t !== pt);
            nc += (clk_c !== pc);
            pt = clk_t;
            pc = clk_c;
        end
        check(nt != 0, exp_t);
        check(nc != 0, exp_c);
    endtask
    task automatic t_strap();
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1:0]);
            check({ref36, diff}, {!i[1], !i[0]});
            check({drv_hi, sine}, 2'b00);
            toggles(1'b1, !i[0]);
            i_rco_host_model.write_reg(8'h05, 8'h01);
            check({drv_hi, sine}, {!i[0], i[0]});
        end
    endtask
    task automatic t_regs();
        logic [8:0] r;
        do_reset(2'h3);
        for (int i = 0; i < 4; i++) begin
            i_rco_host_model.read_reg(i[1:0] == 0 ? 8'h01 : 8'h04 + i, rd);
            check(rd, i == 3 ? 8'h36 : 8'h00);
        end
        i_rco_host_model.read_reg(8'h10, rd);
        check(rd, 8'h00);
        i_rco_host_model.read_reg(8'h08, rd);
        check(rd, 8'h1C);
        i_rco_host_model.start();
        i_rco_host_model.xfer({7'h61, 2'b01}, r);
        i_rco_host_model.stop();
        check(r[0], 1'b1);
    endtask
    task automatic t_override();
        i_rco_host_model.write_reg(8'h01, 8'h01);
        i_rco_host_model.write_reg(8'h05, 8'h0C);
        check({ref36, diff}, 2'b11);
        toggles(1'b1, 1'b1);
        i_rco_host_model.write_reg(8'h05, 8'h02);
        check(buf_en, 1'b0);
        toggles(1'b0, 1'b0);
        i_rco_host_model.write_reg(8'h01, 8'h00);
        i_rco_host_model.write_reg(8'h05, 8'h04);
        check({ref36, diff, buf_en}, 3'b001);
    endtask
    task automatic t_amp();
        for (int v = 0; v < 4; v++) begin
            i_rco_host_model.write_reg(8'h06, v[7:0]);
            check({amp_out, amp_oe_n}, v[1] ? {1'b0, v[0]} : {v[0], 1'b0});
        end
    endtask
    task automatic t_det();
        i_rco_host_model.write_reg(8'h07, 8'h7F);
        check({chg, 1'b0, dis}, 8'hE6);
        i_rco_host_model.read_reg(8'h07, rd);
        check(rd, 8'h7F);
        i_rco_host_model.write_reg(8'h07, 8'h36);
        check({chg, 1'b0, dis}, 8'h63);
    endtask
    initial begin
        t_strap();
        t_regs();
        t_override();
        t_amp();
        t_det();
        stop_test();
    end
endmodule
`default_nettype wire
